// ===== core/lvds_out_pkg.sv
// constants and types shared by the lvds output control design
package lvds_out_pkg;

    // ----------------------------------------------------------------
    // register offsets on the smbus command space
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_DRIVER_ENABLES = 8'h27; // lvds_driver_enables
    localparam logic [7:0] OFS_CLOCK_CONFIG = 8'h28; // lvds_clock_config

    // ----------------------------------------------------------------
    // lvds_driver_enables fields
    // ----------------------------------------------------------------
    localparam int NUM_LANES = 5; // data lanes zero to four
    localparam int BIT_SWING_BOOST = 7; // output_swing_boost
    localparam int BIT_SMBUS_CONTROL = 6; // hand drivers to smbus bits
    localparam int BIT_CLOCK_ENABLE = 5; // forwarded_rx_clock driver
    localparam int BIT_LANE_MSB = 4; // data_lane_four .. data_lane_zero
    localparam logic [7:0] RST_DRIVER_ENABLES = 8'h00;

    // ----------------------------------------------------------------
    // lvds_clock_config fields
    // ----------------------------------------------------------------
    localparam int BIT_BLOCK_RESET = 6; // resets link-side logic
    localparam int BIT_CLOCK_RATE = 5; // clock_rate_select, 1 = ddr
    localparam int BIT_CLOCK_FLIP = 4; // clock_polarity_flip
    localparam int BIT_DELAY_MSB = 3; // clock delay field top
    localparam int BIT_DELAY_LSB = 2; // clock delay field bottom
    localparam logic [7:0] RST_CLOCK_CONFIG = 8'h28; // rate 1, delay 2'b10
    localparam logic [7:0] MASK_CLOCK_CONFIG = 8'h7c; // bits 7 and 1:0 reserved
    localparam int DELAY_STEP_PS = 80; // path delay per delay count

    // ----------------------------------------------------------------
    // smbus slave types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        SMB_IDLE = 3'b000, // waiting for start
        SMB_RECV = 3'b001, // shifting in a byte
        SMB_ACKWAIT = 3'b010, // byte done, waiting to drive ack
        SMB_ACK = 3'b011, // holding ack low for one bit
        SMB_SEND = 3'b100, // shifting out a read byte
        SMB_MACK = 3'b101, // sampling master ack
        SMB_MREL = 3'b110 // master acked, next byte on fall
    } smbState_t;

    typedef enum logic [1:0] {
        KIND_ADDR = 2'b00, // slave address plus direction
        KIND_CMD = 2'b01, // command byte, the register offset
        KIND_DATA = 2'b10 // write data
    } byteKind_t;

endpackage

// ===== core/bit_sync2.sv
// two-flop level synchroniser with a freeze enable
module bit_sync2 #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic en,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);

    // ----------------------------------------------------------------
    // stages
    // ----------------------------------------------------------------
    logic [WIDTH-1:0] meta_ff; // first stage, read only by second
    logic [WIDTH-1:0] dout_ff; // second stage, safe to use

    // first stage catches the foreign level
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= RST_VAL;
        end else if (en) begin
            meta_ff <= din;
        end
    end

    // second stage settles it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dout_ff <= RST_VAL;
        end else if (en) begin
            dout_ff <= meta_ff;
        end
    end

    assign dout = dout_ff;

endmodule

// ===== core/lvds_lane_drive.sv
// link-clock side: lane drivers and forwarded clock generation
module lvds_lane_drive (
    input wire logic lnkClk,
    input wire logic rst_n,
    input wire logic ceSys,
    input wire logic [lvds_out_pkg::NUM_LANES-1:0] laneEnSys,
    input wire logic clkEnSys,
    input wire logic rateDdrSys,
    input wire logic flipSys,
    input wire logic blockRstSys,
    input wire logic [lvds_out_pkg::NUM_LANES-1:0] laneBits,
    output logic [lvds_out_pkg::NUM_LANES-1:0] laneData,
    output logic [lvds_out_pkg::NUM_LANES-1:0] laneOe,
    output logic fwdClock,
    output logic fwdClockOe
);

    localparam int NL = lvds_out_pkg::NUM_LANES;
    localparam int CW = NL + 5; // lanes, clk en, rate, flip, reset, ce

    // ----------------------------------------------------------------
    // crossing of quasi-static settings
    // ----------------------------------------------------------------
    logic [CW-1:0] cfgSync; // settings on lnkClk
    // rate resets to ddr so the clock never starts at half rate
    localparam logic [CW-1:0] CFG_RST = CW'(1) << (NL + 1);

    // multi-bit settings may be seen mixed for one cycle after a change
    bit_sync2 #(.WIDTH(CW), .RST_VAL(CFG_RST)) u_cfg_sync (
        .clk(lnkClk),
        .rst_n(rst_n),
        .en(1'b1),
        .din({ceSys, blockRstSys, flipSys, rateDdrSys, clkEnSys, laneEnSys}),
        .dout(cfgSync)
    );

    wire [NL-1:0] laneEn = cfgSync[NL-1:0]; // per-lane driver enable
    wire clkEn = cfgSync[NL]; // forwarded clock driver enable
    wire rateDdr = cfgSync[NL+1]; // 1 ddr rate, 0 half rate
    wire flip = cfgSync[NL+2]; // invert forwarded clock
    wire blockRst = cfgSync[NL+3]; // soft reset of this logic
    wire ceLnk = cfgSync[NL+4]; // freeze

    // ----------------------------------------------------------------
    // forwarded clock
    // ----------------------------------------------------------------
    logic div_ff; // divides by two for half rate
    logic clkTgl_ff; // clock before polarity
    logic fwdClock_ff; // registered pad level
    logic fwdClockOe_ff; // registered pad enable

    // ddr rate toggles every cycle, half rate every second one
    wire nxt_clkTgl = (rateDdr || div_ff) ? ~clkTgl_ff : clkTgl_ff;

    // soft reset returns the clock to its initial phase
    always_ff @(posedge lnkClk or negedge rst_n) begin
        if (!rst_n) begin
            div_ff <= 1'b0;
            clkTgl_ff <= 1'b0;
            fwdClock_ff <= 1'b0;
            fwdClockOe_ff <= 1'b0;
        end else if (blockRst) begin
            div_ff <= 1'b0;
            clkTgl_ff <= 1'b0;
            fwdClock_ff <= 1'b0;
            fwdClockOe_ff <= 1'b0;
        end else if (ceLnk) begin
            div_ff <= ~div_ff;
            clkTgl_ff <= nxt_clkTgl;
            fwdClock_ff <= (nxt_clkTgl ^ flip) & clkEn;
            fwdClockOe_ff <= clkEn;
        end
    end

    assign fwdClock = fwdClock_ff;
    assign fwdClockOe = fwdClockOe_ff;

    // ----------------------------------------------------------------
    // data lanes
    // ----------------------------------------------------------------
    logic [NL-1:0] laneData_ff; // registered lane bits
    logic [NL-1:0] laneOe_ff; // registered lane driver enables

    genvar g;
    generate
        for (g = 0; g < NL; g++) begin : g_lane
            // a disabled lane parks low so no stale bit leaks out
            always_ff @(posedge lnkClk or negedge rst_n) begin
                if (!rst_n) begin
                    laneData_ff[g] <= 1'b0;
                    laneOe_ff[g] <= 1'b0;
                end else if (blockRst) begin
                    laneData_ff[g] <= 1'b0;
                    laneOe_ff[g] <= 1'b0;
                end else if (ceLnk) begin
                    laneData_ff[g] <= laneBits[g] & laneEn[g];
                    laneOe_ff[g] <= laneEn[g];
                end
            end
        end
    endgenerate

    assign laneData = laneData_ff;
    assign laneOe = laneOe_ff;

endmodule

// ===== core/lvds_output_control_regs.sv
// lvds output control registers behind an smbus slave, with link drivers
// What this block does
// - bit 7 set selects larger output swing
// - bit 6 hands drivers to smbus bits
// - bit 5 enables forwarded clock under override
// - bits 4:0 enable data lanes four..zero under override
// - rate bit: 1 ddr clock, 0 half
// - flip bit inverts forwarded clock polarity
// - delay field adds 80 ps per count
module lvds_output_control_regs #(
    parameter logic [6:0] SMB_ADDR = 7'h3a // arbitrary slave address
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic smbClk,
    input wire logic smbDataIn,
    output logic smbDataOut,
    output logic smbDataOe,
    input wire logic lnkClk,
    input wire logic [lvds_out_pkg::NUM_LANES-1:0] laneBits,
    output logic [lvds_out_pkg::NUM_LANES-1:0] laneData,
    output logic [lvds_out_pkg::NUM_LANES-1:0] laneOe,
    output logic fwdClock,
    output logic fwdClockOe,
    output logic swingBoost,
    output logic [1:0] clkDelayTap
);

    localparam int NL = lvds_out_pkg::NUM_LANES;

    // ----------------------------------------------------------------
    // smbus pin conditioning
    // ----------------------------------------------------------------
    logic [1:0] pinSync; // {clock, data} after two flops
    logic sclDly_ff; // previous synced clock for edges
    logic sdaDly_ff; // previous synced data for start/stop

    // pins come from outside, so two flops before anything looks at them
    bit_sync2 #(.WIDTH(2), .RST_VAL(2'b11)) u_pin_sync (
        .clk(sys_clk),
        .rst_n(rst_n),
        .en(ce),
        .din({smbClk, smbDataIn}),
        .dout(pinSync)
    );

    wire sclS = pinSync[1]; // synced smbus clock
    wire sdaS = pinSync[0]; // synced smbus data

    // edge history taken from the settled stage only
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sclDly_ff <= 1'b1;
            sdaDly_ff <= 1'b1;
        end else if (ce) begin
            sclDly_ff <= sclS;
            sdaDly_ff <= sdaS;
        end
    end

    wire sclRise = sclS & ~sclDly_ff; // master samples here
    wire sclFall = ~sclS & sclDly_ff; // slave changes data here
    wire busStart = sclS & sclDly_ff & sdaDly_ff & ~sdaS; // data falls, clock high
    wire busStop = sclS & sclDly_ff & ~sdaDly_ff & sdaS; // data rises, clock high

    // ----------------------------------------------------------------
    // smbus slave state
    // ----------------------------------------------------------------
    lvds_out_pkg::smbState_t state_ff; // protocol state
    lvds_out_pkg::smbState_t nxt_state;
    lvds_out_pkg::byteKind_t kind_ff; // meaning of byte in flight
    lvds_out_pkg::byteKind_t nxt_kind;
    logic [7:0] shift_ff; // byte shift register
    logic [7:0] nxt_shift;
    logic [2:0] bitCnt_ff; // bit index in byte
    logic [2:0] nxt_bitCnt;
    logic [7:0] ptr_ff; // register pointer from command byte
    logic [7:0] nxt_ptr;
    logic isRead_ff; // direction bit of the last address
    logic nxt_isRead;
    logic sdaOe_ff; // pulls data low while set
    logic nxt_sdaOe;
    logic wrStb; // one-cycle register write strobe

    wire [7:0] rxByte = {shift_ff[6:0], sdaS}; // byte once the eighth bit lands
    wire addrHit = (shift_ff[7:1] == SMB_ADDR); // address compare after receive
    wire [7:0] rdData; // selected register for reads

    // ----------------------------------------------------------------
    // smbus slave next state
    // ----------------------------------------------------------------
    // start and stop win over everything, so a hung transfer recovers
    always_comb begin
        nxt_state = state_ff;
        nxt_kind = kind_ff;
        nxt_shift = shift_ff;
        nxt_bitCnt = bitCnt_ff;
        nxt_ptr = ptr_ff;
        nxt_isRead = isRead_ff;
        nxt_sdaOe = sdaOe_ff;
        wrStb = 1'b0;
        if (busStop) begin
            nxt_state = lvds_out_pkg::SMB_IDLE;
            nxt_sdaOe = 1'b0;
        end else if (busStart) begin
            // repeated start keeps the pointer for the read phase
            nxt_state = lvds_out_pkg::SMB_RECV;
            nxt_kind = lvds_out_pkg::KIND_ADDR;
            nxt_bitCnt = 3'h0;
            nxt_sdaOe = 1'b0;
        end else begin
            case (state_ff)
                lvds_out_pkg::SMB_IDLE: begin
                    nxt_sdaOe = 1'b0;
                end
                lvds_out_pkg::SMB_RECV: begin
                    // shift on each rising clock edge
                    if (sclRise) begin
                        nxt_shift = rxByte;
                        nxt_bitCnt = bitCnt_ff + 3'h1;
                        if (bitCnt_ff == 3'h7) begin
                            nxt_state = lvds_out_pkg::SMB_ACKWAIT;
                        end
                    end
                end
                lvds_out_pkg::SMB_ACKWAIT: begin
                    // decide ack and act on the byte at the falling edge
                    if (sclFall) begin
                        if (kind_ff == lvds_out_pkg::KIND_ADDR) begin
                            nxt_isRead = shift_ff[0];
                            nxt_sdaOe = addrHit;
                            nxt_state = addrHit ? lvds_out_pkg::SMB_ACK
                                                : lvds_out_pkg::SMB_IDLE;
                        end else if (kind_ff == lvds_out_pkg::KIND_CMD) begin
                            nxt_ptr = shift_ff;
                            nxt_sdaOe = 1'b1;
                            nxt_state = lvds_out_pkg::SMB_ACK;
                        end else begin
                            wrStb = 1'b1;
                            nxt_sdaOe = 1'b1;
                            nxt_state = lvds_out_pkg::SMB_ACK;
                        end
                    end
                end
                lvds_out_pkg::SMB_ACK: begin
                    // release ack and move on to the following byte
                    if (sclFall) begin
                        nxt_bitCnt = 3'h0;
                        nxt_sdaOe = 1'b0;
                        nxt_state = lvds_out_pkg::SMB_RECV;
                        if (kind_ff == lvds_out_pkg::KIND_ADDR && isRead_ff) begin
                            nxt_shift = rdData;
                            nxt_sdaOe = ~rdData[7];
                            nxt_state = lvds_out_pkg::SMB_SEND;
                        end else if (kind_ff == lvds_out_pkg::KIND_ADDR) begin
                            nxt_kind = lvds_out_pkg::KIND_CMD;
                        end else if (kind_ff == lvds_out_pkg::KIND_CMD) begin
                            nxt_kind = lvds_out_pkg::KIND_DATA;
                        end else begin
                            // block writes walk the pointer upward
                            nxt_ptr = ptr_ff + 8'h01;
                        end
                    end
                end
                lvds_out_pkg::SMB_SEND: begin
                    // present the next bit after each falling edge
                    if (sclFall) begin
                        if (bitCnt_ff == 3'h7) begin
                            nxt_sdaOe = 1'b0;
                            nxt_state = lvds_out_pkg::SMB_MACK;
                        end else begin
                            nxt_shift = {shift_ff[6:0], 1'b0};
                            nxt_sdaOe = ~shift_ff[6];
                            nxt_bitCnt = bitCnt_ff + 3'h1;
                        end
                    end
                end
                lvds_out_pkg::SMB_MACK: begin
                    // a nack ends the read; an ack asks for more
                    if (sclRise) begin
                        if (!sdaS) begin
                            nxt_ptr = ptr_ff + 8'h01;
                            nxt_state = lvds_out_pkg::SMB_MREL;
                        end else begin
                            nxt_state = lvds_out_pkg::SMB_IDLE;
                        end
                    end
                end
                lvds_out_pkg::SMB_MREL: begin
                    if (sclFall) begin
                        nxt_shift = rdData;
                        nxt_sdaOe = ~rdData[7];
                        nxt_bitCnt = 3'h0;
                        nxt_state = lvds_out_pkg::SMB_SEND;
                    end
                end
                default: begin
                    nxt_state = lvds_out_pkg::SMB_IDLE;
                    nxt_sdaOe = 1'b0;
                end
            endcase
        end
    end

    // protocol registers
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= lvds_out_pkg::SMB_IDLE;
            kind_ff <= lvds_out_pkg::KIND_ADDR;
            shift_ff <= 8'h00;
            bitCnt_ff <= 3'h0;
            ptr_ff <= 8'h00;
            isRead_ff <= 1'b0;
            sdaOe_ff <= 1'b0;
        end else if (ce) begin
            state_ff <= nxt_state;
            kind_ff <= nxt_kind;
            shift_ff <= nxt_shift;
            bitCnt_ff <= nxt_bitCnt;
            ptr_ff <= nxt_ptr;
            isRead_ff <= nxt_isRead;
            sdaOe_ff <= nxt_sdaOe;
        end
    end

    // open-drain: only ever pulls low
    assign smbDataOut = 1'b0;
    assign smbDataOe = sdaOe_ff;

    // ----------------------------------------------------------------
    // configuration registers
    // ----------------------------------------------------------------
    logic [7:0] drvEn_ff; // lvds_driver_enables
    logic [7:0] clkCfg_ff; // lvds_clock_config

    wire wrDrv = wrStb && (ptr_ff == lvds_out_pkg::OFS_DRIVER_ENABLES);
    wire wrClk = wrStb && (ptr_ff == lvds_out_pkg::OFS_CLOCK_CONFIG);

    // writes to unmapped offsets fall on the floor
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            drvEn_ff <= lvds_out_pkg::RST_DRIVER_ENABLES;
            clkCfg_ff <= lvds_out_pkg::RST_CLOCK_CONFIG;
        end else if (ce) begin
            if (wrDrv) begin
                drvEn_ff <= shift_ff;
            end
            if (wrClk) begin
                clkCfg_ff <= shift_ff & lvds_out_pkg::MASK_CLOCK_CONFIG;
            end
        end
    end

    // read mux, unmapped offsets return zero
    assign rdData = (ptr_ff == lvds_out_pkg::OFS_DRIVER_ENABLES) ? drvEn_ff :
                    (ptr_ff == lvds_out_pkg::OFS_CLOCK_CONFIG) ? clkCfg_ff : 8'h00;

    // ----------------------------------------------------------------
    // decoded controls
    // ----------------------------------------------------------------
    wire smbCtl = drvEn_ff[lvds_out_pkg::BIT_SMBUS_CONTROL];
    // without the override every driver stays on, as after power-up
    wire [NL-1:0] laneEnEff = smbCtl ? drvEn_ff[lvds_out_pkg::BIT_LANE_MSB:0]
                                     : {NL{1'b1}};
    wire clkEnEff = smbCtl ? drvEn_ff[lvds_out_pkg::BIT_CLOCK_ENABLE] : 1'b1;
    wire rateDdr = clkCfg_ff[lvds_out_pkg::BIT_CLOCK_RATE];
    wire flipClk = clkCfg_ff[lvds_out_pkg::BIT_CLOCK_FLIP];
    wire blockRst = clkCfg_ff[lvds_out_pkg::BIT_BLOCK_RESET];

    // analog pad controls straight from the register flops
    assign swingBoost = drvEn_ff[lvds_out_pkg::BIT_SWING_BOOST];
    // each count steps the delay line by DELAY_STEP_PS
    assign clkDelayTap = clkCfg_ff[lvds_out_pkg::BIT_DELAY_MSB:lvds_out_pkg::BIT_DELAY_LSB];

    // ----------------------------------------------------------------
    // link-clock side
    // ----------------------------------------------------------------
    lvds_lane_drive u_lane_drive (
        .lnkClk(lnkClk),
        .rst_n(rst_n),
        .ceSys(ce),
        .laneEnSys(laneEnEff),
        .clkEnSys(clkEnEff),
        .rateDdrSys(rateDdr),
        .flipSys(flipClk),
        .blockRstSys(blockRst),
        .laneBits(laneBits),
        .laneData(laneData),
        .laneOe(laneOe),
        .fwdClock(fwdClock),
        .fwdClockOe(fwdClockOe)
    );

endmodule

// ===== tb/lvds_output_control_regs_properties.sv
// port checker for the lvds output control block
module lvds_output_control_regs_checker (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic smbClk,
    input wire logic smbDataOe,
    input wire logic lnkClk,
    input wire logic [4:0] laneBits,
    input wire logic [4:0] laneData,
    input wire logic [4:0] laneOe,
    input wire logic fwdClock,
    input wire logic fwdClockOe,
    input wire logic swingBoost,
    input wire logic [1:0] clkDelayTap
);
    // ------------
    // link side
    // ------------
    a_lane_gating: assert property (@(posedge lnkClk) disable iff (!rst_n)
        laneData == ($past(laneBits) & laneOe)) else $error("lane data not gated");
    a_clock_gated: assert property (@(posedge lnkClk) disable iff (!rst_n)
        !fwdClockOe |-> !fwdClock) else $error("clock runs while disabled");
    // ------------
    // register side, updates only while the bus clock is low
    // ------------
    a_reset_values: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(rst_n) |-> clkDelayTap == 2'b10 && !swingBoost) else $error("bad reset value");
    a_tap_on_low: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $changed(clkDelayTap) |-> !smbClk) else $error("delay tap moved mid bit");
    a_swing_on_low: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $changed(swingBoost) |-> !smbClk) else $error("swing moved mid bit");
    a_ack_on_low: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(smbDataOe) |-> !smbClk) else $error("data pulled while clock high");
    a_release_low: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $fell(smbDataOe) |-> !smbClk) else $error("data freed while clock high");
    a_sda_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
        smbClk && $past(smbClk) |-> $stable(smbDataOe)) else $error("data moved in high");
    // main scenarios
    c_ack: cover property (@(posedge sys_clk) $rose(smbDataOe));
    c_lanes_off: cover property (@(posedge lnkClk) $fell(laneOe[0]));
    c_boost: cover property (@(posedge sys_clk) $rose(swingBoost));
endmodule

bind lvds_output_control_regs lvds_output_control_regs_checker lvds_output_control_regs_checker_i (.*);

// ===== tb/lvds_host_rx.sv
// host receiver model: measures the forwarded clock's edge spacing
module lvds_host_rx (
    input wire logic lnkClk,
    input wire logic rst_n,
    input wire logic fwdClock,
    output logic [3:0] clkGap
);
    timeunit 1ns;
    timeprecision 1ps;
    logic last_ff; // clock level one link cycle ago
    logic [3:0] run_ff; // stable cycles, saturates so a dead clock stays visible
    logic [3:0] gap_ff;
    assign clkGap = gap_ff;
    // link cycles between two clock edges
    always_ff @(posedge lnkClk or negedge rst_n) begin
        if (!rst_n) begin
            last_ff <= 1'b0;
            run_ff <= 4'h0;
            gap_ff <= 4'h0;
        end else begin
            last_ff <= fwdClock;
            if (fwdClock != last_ff) begin
                gap_ff <= run_ff + 4'h1;
                run_ff <= 4'h0;
            end else if (run_ff != 4'hf) begin
                run_ff <= run_ff + 4'h1;
            end
        end
    end
endmodule

// ===== tb/lvds_output_control_regs_tb_top.sv
// self-checking bench for the lvds output control block
module lvds_output_control_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [6:0] ADDR = 7'h3a; // arbitrary slave address
    logic sys_clk = 0, rst_n = 0, lnkClk = 0, sclM = 1, sdaM = 1;
    logic [4:0] laneBits = '0, laneData, laneOe;
    logic smbDataOe, smbDataOut, fwdClock, fwdClockOe, swingBoost;
    logic [1:0] clkDelayTap;
    logic [3:0] clkGap;
    int n_fail = 0, tests_run = 0, cyc = 0;
    wire sda = sdaM & ~smbDataOe; // open drain, pulled up
    initial forever #25 sys_clk = ~sys_clk;
    initial begin
        #3.7;
        forever #6 lnkClk = ~lnkClk;
    end
    always @(posedge lnkClk) laneBits <= 5'($urandom);
    lvds_output_control_regs #(.SMB_ADDR(ADDR)) lvds_output_control_regs_i (
        .sys_clk, .rst_n, .ce(1'b1), .smbClk(sclM), .smbDataIn(sda), .smbDataOut,
        .smbDataOe, .lnkClk, .laneBits, .laneData, .laneOe, .fwdClock, .fwdClockOe,
        .swingBoost, .clkDelayTap);
    lvds_host_rx lvds_host_rx_i (.lnkClk, .rst_n, .fwdClock, .clkGap);
    // hang guard
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            n_fail++;
            final_report;
        end
    end
    // ------------
    // checks and expectations
    // ------------
    task final_report;
        if (n_fail == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task chkReg(input logic [7:0] got, exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t reg got %h exp %h", $time, got, exp);
        end
    endtask
    task chkPin(input logic [7:0] got, exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t pins got %h exp %h", $time, got, exp);
        end
    endtask
    // without the override every driver is on
    function automatic logic [5:0] expOe(input logic [7:0] d);
        return d[6] ? d[5:0] : 6'h3f;
    endfunction
    // ------------
    // bus master, steps of 10 system cycles: clock high for one step, low for two
    // ------------
    task hp;
        repeat (10) @(posedge sys_clk);
    endtask
    task settle;
        repeat (20) @(posedge sys_clk);
    endtask
    // data moves mid low phase so it never looks like start or stop
    task sbit(input logic b, output logic r);
        sdaM <= b;
        hp;
        sclM <= 1'b1;
        hp;
        r = sda;
        sclM <= 1'b0;
        hp;
    endtask
    task start;
        sdaM <= 1'b1;
        hp;
        sclM <= 1'b1;
        hp;
        sdaM <= 1'b0;
        hp;
        sclM <= 1'b0;
        hp;
    endtask
    task stop;
        sdaM <= 1'b0;
        hp;
        sclM <= 1'b1;
        hp;
        sdaM <= 1'b1;
        hp;
    endtask
    task sbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) sbit(d[i], r);
        sbit(1'b1, r);
        ack = ~r;
    endtask
    task wreg(input logic [7:0] ofs, input logic [7:0] d);
        logic a0, a1, a2;
        start;
        sbyte({ADDR, 1'b0}, a0);
        sbyte(ofs, a1);
        sbyte(d, a2);
        stop;
        chkPin({5'h0, a0, a1, a2}, 8'h07);
    endtask
    // last byte is refused so the slave ends the read
    task rreg(input logic [7:0] ofs, output logic [7:0] d);
        logic a;
        start;
        sbyte({ADDR, 1'b0}, a);
        sbyte(ofs, a);
        start;
        sbyte({ADDR, 1'b1}, a);
        for (int i = 7; i >= 0; i--) sbit(1'b1, d[i]);
        sbit(1'b1, a);
        stop;
    endtask
    // ------------
    // main sequence
    // ------------
    initial begin
        logic [7:0] d, v;
        logic a;
        void'($urandom(32'hf98da660));
        repeat (16) @(posedge sys_clk);
        chkPin({6'h0, clkDelayTap}, 8'h02);
        rst_n <= 1'b1;
        settle;
        chkPin({2'b0, fwdClockOe, laneOe}, 8'h3f);
        rreg(8'h27, v);
        chkReg(v, 8'h00);
        rreg(8'h28, v);
        chkReg(v, 8'h28);
        chkPin({4'h0, clkGap}, 8'h01);
        // driver enables: corners, random, then clock only
        for (int i = 0; i < 6; i++) begin
            d = (i == 0) ? 8'hc0 : (i == 1) ? 8'h7f : (i == 5) ? 8'h60 : 8'($urandom);
            wreg(8'h27, d);
            settle;
            rreg(8'h27, v);
            chkReg(v, d);
            chkPin({2'b0, fwdClockOe, laneOe}, {2'b0, expOe(d)});
            chkPin({7'h0, swingBoost}, {7'h0, d[7]});
        end
        // every rate and polarity pair, random delay and reserved bits 1:0
        for (int i = 0; i < 4; i++) begin
            d = {2'b00, i[1:0], 2'($urandom), 2'($urandom)};
            wreg(8'h28, d);
            settle;
            rreg(8'h28, v);
            chkReg(v, d & 8'h7c);
            chkPin({6'h0, clkDelayTap}, {6'h0, d[3:2]});
            chkPin({4'h0, clkGap}, d[5] ? 8'h01 : 8'h02);
        end
        // soft reset silences the link but keeps the registers
        wreg(8'h28, 8'h68);
        settle;
        chkPin({1'b0, fwdClock, fwdClockOe, laneOe}, 8'h00);
        rreg(8'h27, v);
        chkReg(v, 8'h60);
        wreg(8'h28, 8'h28);
        settle;
        chkPin({2'b0, fwdClockOe, laneOe}, 8'h20);
        // unmapped offset and a foreign slave address
        rreg(8'h30, v);
        chkReg(v, 8'h00);
        start;
        sbyte(8'h10, a);
        stop;
        chkPin({6'h0, smbDataOut, a}, 8'h00);
        final_report;
    end
endmodule
